// [tlpt_dev.sv]
// packet port end: word buffer, frame checker and link-side output
//
// Notes on behaviour
// - report free buffers, six bits, at most 32
// - one buffer holds one maximum-size packet
// - raise request when internal packet is ready
// - internal packet goes out only under grant
// - user may hold grant high permanently
// - sink ready only when a word fits
// - source valid only with real data
// - word moves when valid and ready meet
// - start marker on a packet's first word
// - end marker on a packet's last word
// - digest request makes link add/recompute digest
// - digest request comes with the start word
// - poison anywhere in frame taints packet
// - drop and flag on length or gap
// - too long or header mismatch is violation
// - remainder read only on accepted end word
// - 64-bit remainder: 1 full, 0 upper half
// - 128-bit remainder selects valid upper dwords
// - source abort makes the packet dropped (code ignores an abort on the start word itself)
// - streamed packets arrive back to back
`timescale 1ns/10ps

// ---------------------------------------------------------------
// word buffer
// ---------------------------------------------------------------
module tlpt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         in_valid_i,
  output logic                              in_ready_o,
  input  wire logic [W-1:0]                 in_data_i,
  output logic                              out_valid_o,
  input  wire logic                         out_ready_i,
  output logic [W-1:0]                      out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]        count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } tlpt_fifo_s;

  tlpt_fifo_s s;
  tlpt_fifo_s next_s;
  logic       push;
  logic       pop;

  assign in_ready_o  = (s.cnt != FULL);
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];
  assign count_o     = s.cnt;

  always_comb begin
    next_s = s;
    push   = in_valid_i && in_ready_o;
    pop    = out_valid_o && out_ready_i;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---------------------------------------------------------------
// packet port end
// ---------------------------------------------------------------
module tlpt_dev #(
  parameter int NUM_BUFS       = tlpt_pkg::MAX_BUFS,
  parameter int MAX_PAYLOAD_DW = tlpt_pkg::MAX_PAYLOAD_DW,
  parameter int DEPTH          = tlpt_pkg::FIFO_DEPTH,
  parameter bit BUS64          = 1'b0
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  tlpt_if.dev                                bus,
  input  wire logic                          int_pkt_pending_i,
  input  wire logic [tlpt_pkg::DATA_W-1:0]   int_pkt_data_i,
  output logic                               int_pkt_taken_o,
  input  wire logic                          link_ready_i,
  output logic                               link_valid_o,
  output tlpt_pkg::tlpt_word_s               link_word_o
);
  import tlpt_pkg::*;

  localparam int CW = $clog2(DEPTH+1);
  localparam logic [DWC_W-1:0] MAX_TOTAL =
    DWC_W'(MAX_PAYLOAD_DW + HDR4_DW + DIGEST_DW);
  localparam logic [BUFCNT_W-1:0] BUFS =
    (NUM_BUFS > MAX_BUFS) ? BUFCNT_W'(MAX_BUFS) : BUFCNT_W'(NUM_BUFS);
  localparam logic [2:0] PER_WORD = BUS64 ? DW_PER_WORD64 : DW_PER_WORD128;

  typedef struct packed {
    logic                ready;
    logic                inject;
    logic                req;
    logic                taken;
    logic                drop;
    logic                fr;
    logic                sk;
    logic                st;
    logic                po;
    logic [DWC_W-1:0]    dwc;
    logic [DWC_W-1:0]    expd;
    logic [BUFCNT_W-1:0] free;
    logic [BUFCNT_W-1:0] q;
    logic                lk_valid;
    tlpt_word_s          lk;
  } tlpt_dev_s;

  tlpt_dev_s        s;
  tlpt_dev_s        next_s;
  tlpt_word_s       w;
  tlpt_word_s       f_out;
  logic             wr;
  logic             f_in_ready;
  logic             f_out_valid;
  logic             f_out_ready;
  logic [CW-1:0]    f_count;
  logic [CW:0]      cnt_next;
  logic             room;
  logic             xfer;
  logic             sof;
  logic             eof;
  logic             viol;
  logic             po_acc;
  logic [DWC_W-1:0] cnt;
  logic [DWC_W-1:0] expv;

  tlpt_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) tlpt_fifo_i (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr),
    .in_ready_o  (f_in_ready),
    .in_data_i   (w),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out),
    .count_o     (f_count)
  );

  assign bus.tx_sink_ready           = s.ready;
  assign bus.free_tx_buffer_count    = s.free;
  assign bus.tx_drop_flag            = s.drop;
  assign bus.internal_packet_request = s.req;
  assign int_pkt_taken_o             = s.taken;
  assign link_valid_o                = s.lk_valid;
  assign link_word_o                 = s.lk;
  assign f_out_ready                 = !s.lk_valid || link_ready_i;

  always_comb begin
    next_s = s;
    w      = '0;
    wr     = 1'b0;
    viol   = 1'b0;
    cnt    = '0;
    expv   = '0;
    po_acc = 1'b0;
    sof    = bus.tx_start_of_frame;
    eof    = bus.tx_end_of_frame;
    xfer   = bus.tx_source_valid && s.ready;
    next_s.drop  = 1'b0;
    next_s.taken = s.inject;
    next_s.po    = s.po | (s.fr & bus.tx_poison_mark);

    if (s.inject) begin
      // sink ready is held low this cycle, so no user word collides
      wr       = 1'b1;
      w.data   = int_pkt_data_i;
      w.sof    = 1'b1;
      w.eof    = 1'b1;
      w.rem    = REM_ALL;
    end else if ((s.fr || s.sk) && bus.tx_source_abort && s.ready) begin
      // terminator marks the buffered part for the link to discard
      wr        = s.fr;
      w.data    = bus.tx_data_bus;
      w.eof     = 1'b1;
      w.abort   = 1'b1;
      next_s.fr = 1'b0;
      next_s.sk = 1'b0;
      next_s.po = 1'b0;
    end else if (xfer && (sof || s.fr)) begin
      cnt  = (sof ? '0 : s.dwc)
           + (eof ? DWC_W'(dw_last(BUS64,
                      bus.tx_final_word_remainder))
                  : DWC_W'(PER_WORD));
      expv = sof ? hdr_total(BUS64, bus.tx_data_bus) : s.expd;
      viol = (cnt > MAX_TOTAL) || (eof && (cnt != expv));
      po_acc = (sof ? 1'b0 : s.po) | bus.tx_poison_mark;
      wr       = 1'b1;
      w.data   = bus.tx_data_bus;
      w.sof    = sof;
      w.eof    = eof | viol;
      w.abort  = viol;
      w.poison = po_acc & (eof | viol);
      w.digest = sof & bus.digest_generate_request;
      w.stream = sof ? bus.tx_cut_through_flag : s.st;
      w.rem    = eof ? bus.tx_final_word_remainder : '0;
      next_s.fr   = !(eof || viol);
      next_s.sk   = viol && !eof;
      next_s.drop = viol;
      next_s.dwc  = cnt;
      next_s.expd = expv;
      next_s.st   = sof ? bus.tx_cut_through_flag : s.st;
      next_s.po   = next_s.fr ? po_acc : 1'b0;
    end else if (xfer && s.sk) begin
      // rest of a dropped packet is swallowed up to its end word
      next_s.sk = !eof;
    end else if (s.fr && s.st && s.ready && !bus.tx_source_valid) begin
      // a streamed packet may already be on the link: cut it off
      wr          = 1'b1;
      w.eof       = 1'b1;
      w.abort     = 1'b1;
      next_s.fr   = 1'b0;
      next_s.sk   = 1'b1;
      next_s.drop = 1'b1;
      next_s.po   = 1'b0;
    end

    // one buffer per queued packet, released when its end leaves
    next_s.q = s.q + BUFCNT_W'(wr && w.eof)
             - BUFCNT_W'(s.lk_valid && link_ready_i && s.lk.eof);
    next_s.free = BUFS - next_s.q;

    if (f_out_ready) begin
      next_s.lk_valid = f_out_valid;
      if (f_out_valid) begin
        next_s.lk = f_out;
      end
    end

    // exact next fill level, so ready never promises a lost word
    cnt_next = (CW+1)'(f_count) + (CW+1)'(wr)
             - (CW+1)'(f_out_valid && f_out_ready);
    room = (cnt_next < (CW+1)'(DEPTH)) && f_in_ready;

    next_s.inject = s.req && bus.internal_packet_grant
                  && !next_s.fr && !next_s.sk && !s.inject && room;
    next_s.req    = int_pkt_pending_i
                  && !next_s.inject && !s.inject;
    next_s.ready  = room && !next_s.inject
                  && (next_s.fr || next_s.sk || (next_s.free != '0));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.free <= BUFS;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [tlpt_pkg.sv]
// shared constants, word layout and decoders for the tlp transmit port
package tlpt_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int DATA_W      = 128;
  localparam int REM_W       = 2;
  localparam int BUFCNT_W    = 6;
  localparam int MAX_BUFS    = 32;
  localparam int FIFO_DEPTH  = 8;
  localparam int DW_W        = 32;

  localparam logic [2:0] DW_PER_WORD128 = 3'h4;
  localparam logic [2:0] DW_PER_WORD64  = 3'h2;

  // final-word remainder codes, 128-bit bus
  localparam logic [1:0] REM_ALL = 2'h3;
  localparam logic [1:0] REM_3DW = 2'h2;
  localparam logic [1:0] REM_2DW = 2'h1;
  localparam logic [1:0] REM_1DW = 2'h0;
  // bit 0 alone is used on a 64-bit bus
  localparam int         REM64_FULL_BIT = 0;

  // ---------------------------------------------------------------
  // header fields, first dword of the start word
  // ---------------------------------------------------------------
  localparam int DW0_LSB128   = 96;
  localparam int DW0_LSB64    = 32;
  localparam int FMT_DATA_BIT = 30;
  localparam int FMT_4DW_BIT  = 29;
  localparam int TD_BIT       = 15;
  localparam int LEN_LSB      = 0;
  localparam int LEN_W        = 10;

  localparam int DWC_W          = 11;
  localparam int LEN_ZERO_DW    = 1024;
  localparam int HDR3_DW        = 3;
  localparam int HDR4_DW        = 4;
  localparam int DIGEST_DW      = 1;
  localparam int MAX_PAYLOAD_DW = 256;

  // ---------------------------------------------------------------
  // buffered word
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              abort;
    logic              poison;
    logic              digest;
    logic              stream;
    logic              sof;
    logic              eof;
    logic [REM_W-1:0]  rem;
    logic [DATA_W-1:0] data;
  } tlpt_word_s;

  localparam int WORD_W = $bits(tlpt_word_s);

  // dwords carried by the final word of a packet
  function automatic logic [2:0] dw_last(input logic             bus64,
                                         input logic [REM_W-1:0] rem);
    logic [2:0] n;
    n = 3'h1;
    if (bus64) begin
      n = rem[REM64_FULL_BIT] ? 3'h2 : 3'h1;
    end else begin
      unique case (rem)
        REM_ALL: n = 3'h4;
        REM_3DW: n = 3'h3;
        REM_2DW: n = 3'h2;
        REM_1DW: n = 3'h1;
      endcase
    end
    return n;
  endfunction

  // total dwords that the header announces, digest included
  function automatic logic [DWC_W-1:0] hdr_total(
      input logic              bus64,
      input logic [DATA_W-1:0] d);
    logic [DW_W-1:0]  dw0;
    logic [DWC_W-1:0] len;
    logic [DWC_W-1:0] tot;
    dw0 = bus64 ? d[DW0_LSB64 +: DW_W] : d[DW0_LSB128 +: DW_W];
    len = (dw0[LEN_LSB +: LEN_W] == '0) ? DWC_W'(LEN_ZERO_DW)
                                        : DWC_W'(dw0[LEN_LSB +: LEN_W]);
    tot = dw0[FMT_4DW_BIT] ? DWC_W'(HDR4_DW) : DWC_W'(HDR3_DW);
    if (dw0[FMT_DATA_BIT]) begin
      tot = tot + len;
    end
    if (dw0[TD_BIT]) begin
      tot = tot + DWC_W'(DIGEST_DW);
    end
    return tot;
  endfunction

endpackage

// [tlpt_if.sv]
// transmit-side connection between user logic and the packet port
`timescale 1ns/10ps
interface tlpt_if;
  import tlpt_pkg::*;

  logic [DATA_W-1:0]   tx_data_bus;
  logic                tx_start_of_frame;
  logic                tx_end_of_frame;
  logic [REM_W-1:0]    tx_final_word_remainder;
  logic                tx_source_valid;
  logic                tx_sink_ready;
  logic                digest_generate_request;
  logic                tx_poison_mark;
  logic                tx_source_abort;
  logic                tx_cut_through_flag;
  logic [BUFCNT_W-1:0] free_tx_buffer_count;
  logic                tx_drop_flag;
  logic                internal_packet_request;
  logic                internal_packet_grant;

  modport dev (
    input  tx_data_bus, tx_start_of_frame, tx_end_of_frame,
    input  tx_final_word_remainder, tx_source_valid,
    input  digest_generate_request, tx_poison_mark, tx_source_abort,
    input  tx_cut_through_flag, internal_packet_grant,
    output tx_sink_ready, free_tx_buffer_count, tx_drop_flag,
    output internal_packet_request
  );

  modport usr (
    output tx_data_bus, tx_start_of_frame, tx_end_of_frame,
    output tx_final_word_remainder, tx_source_valid,
    output digest_generate_request, tx_poison_mark, tx_source_abort,
    output tx_cut_through_flag, internal_packet_grant,
    input  tx_sink_ready, free_tx_buffer_count, tx_drop_flag,
    input  internal_packet_request
  );

endinterface

// [tlpt_usr.sv]
// user end: two-word holding stage that drives the packet port
`timescale 1ns/10ps
module tlpt_usr #(
  parameter bit ALWAYS_GRANT = 1'b0
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  tlpt_if.usr                                bus,
  input  wire logic                          usr_valid_i,
  output logic                               usr_ready_o,
  input  wire tlpt_pkg::tlpt_word_s          usr_word_i,
  input  wire logic                          usr_hold_internal_i,
  output logic [tlpt_pkg::BUFCNT_W-1:0]      usr_free_bufs_o,
  output logic                               usr_drop_o,
  output logic                               usr_int_req_o
);
  import tlpt_pkg::*;

  typedef struct packed {
    logic                v0;
    logic                v1;
    tlpt_word_s          w0;
    tlpt_word_s          w1;
    logic                ready;
    logic                grant;
    logic [BUFCNT_W-1:0] free;
    logic                drop;
    logic                ireq;
  } tlpt_usr_s;

  tlpt_usr_s s;
  tlpt_usr_s next_s;
  logic      pop;
  logic      push;

  // ---------------------------------------------------------------
  // port drive: head word stays put until taken
  // ---------------------------------------------------------------
  assign bus.tx_data_bus             = s.w0.data;
  assign bus.tx_start_of_frame       = s.w0.sof;
  assign bus.tx_end_of_frame         = s.w0.eof;
  assign bus.tx_final_word_remainder = s.w0.rem;
  assign bus.tx_source_valid         = s.v0;
  assign bus.digest_generate_request = s.w0.digest & s.w0.sof;
  assign bus.tx_poison_mark          = s.w0.poison & s.v0;
  assign bus.tx_source_abort         = s.w0.abort & s.v0;
  assign bus.tx_cut_through_flag     = s.w0.stream;
  assign bus.internal_packet_grant   = s.grant;
  assign usr_ready_o                 = s.ready;
  assign usr_free_bufs_o             = s.free;
  assign usr_drop_o                  = s.drop;
  assign usr_int_req_o               = s.ireq;

  // ---------------------------------------------------------------
  // holding stage
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    pop    = s.v0 && bus.tx_sink_ready;
    push   = usr_valid_i && s.ready;
    if (pop) begin
      next_s.v0 = s.v1;
      next_s.w0 = s.w1;
      next_s.v1 = 1'b0;
    end
    if (push) begin
      if (!next_s.v0) begin
        next_s.v0 = 1'b1;
        next_s.w0 = usr_word_i;
      end else begin
        next_s.v1 = 1'b1;
        next_s.w1 = usr_word_i;
      end
    end
    // second slot keeps a streamed source running at full rate
    next_s.ready = !next_s.v1;
    next_s.grant = !usr_hold_internal_i
                 && (bus.internal_packet_request || ALWAYS_GRANT);
    next_s.free  = bus.free_tx_buffer_count;
    next_s.drop  = bus.tx_drop_flag;
    next_s.ireq  = bus.internal_packet_request;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// [tlpt_props.sv]
// assertion checker watching the tlp transmit port interface
`timescale 1ns/10ps
module tlpt_props
  import tlpt_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [DATA_W-1:0]   tx_data_bus,
  input  wire logic                tx_start_of_frame,
  input  wire logic                tx_end_of_frame,
  input  wire logic                tx_source_valid,
  input  wire logic                tx_sink_ready,
  input  wire logic                tx_source_abort,
  input  wire logic                tx_cut_through_flag,
  input  wire logic [BUFCNT_W-1:0] free_tx_buffer_count,
  input  wire logic                tx_drop_flag,
  input  wire logic                internal_packet_request,
  input  wire logic                internal_packet_grant
);
  // --------
  // frame tracking
  // --------
  logic acc;
  logic gap;
  logic in_frm;
  logic strm;
  logic bad;
  assign acc = tx_source_valid && tx_sink_ready;
  // only the first gap of a frame is reported, the rest is swallowed
  assign gap = in_frm && strm && !bad && tx_sink_ready && !tx_source_valid;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_frm <= 1'b0;
      strm   <= 1'b0;
      bad    <= 1'b0;
    end else if (acc && tx_source_abort) begin
      in_frm <= 1'b0;
    end else if (acc && tx_start_of_frame && !in_frm) begin
      in_frm <= !tx_end_of_frame;
      strm   <= tx_cut_through_flag;
      bad    <= 1'b0;
    end else if (acc && tx_end_of_frame) begin
      in_frm <= 1'b0;
    end else if (gap) begin
      bad <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_BUF_MAX: assert property (free_tx_buffer_count <= 6'h20)
    else $error("free buffer count above 32");
  AST_BUF_RST: assert property ($fell(rst_i) |->
    free_tx_buffer_count == 6'h20) else $error("free count not 32");
  AST_RDY_RST: assert property ($fell(rst_i) |->
    !tx_sink_ready ##1 tx_sink_ready) else $error("ready after reset");
  AST_REQ_HOLD: assert property (internal_packet_request &&
    !internal_packet_grant |=> internal_packet_request)
    else $error("request dropped without grant");
  AST_INJ: assert property ($fell(internal_packet_request) |->
    $past(internal_packet_grant) && !tx_sink_ready)
    else $error("internal packet sent without grant");
  AST_DROP_PULSE: assert property (tx_drop_flag |=> !tx_drop_flag)
    else $error("drop flag longer than one cycle");
  AST_GAP: assert property (gap |=> tx_drop_flag)
    else $error("streamed gap not reported");
  AST_HOLD: assert property (tx_source_valid && !tx_sink_ready |=>
    tx_source_valid && $stable(tx_data_bus) && $stable(tx_end_of_frame))
    else $error("word changed before it was taken");

  cover property (gap ##1 tx_drop_flag);
  cover property ($fell(internal_packet_request));
  cover property (tx_source_valid && !tx_sink_ready);
  cover property (acc && tx_source_abort);
endmodule

// [tlp_transmit_user_port_bench.sv]
// bench joining the user end and the packet port back to back
`timescale 1ns/10ps
module tlp_transmit_user_port_bench;
  import tlpt_pkg::*;
  logic              clk_i;
  logic              rst_i;
  logic              usr_valid;
  logic              usr_ready;
  tlpt_word_s        wd;
  logic              hold;
  logic [5:0]        free;
  logic              ireq;
  logic              pend;
  logic [DATA_W-1:0] idata;
  logic              taken;
  logic              lrdy;
  logic              lvld;
  tlpt_word_s        lword;
  tlpt_word_s        got[$];
  int                err_total, checked, drops, eofs, cyc, i, n, e0;
  bit                ok;
  logic              udrop;
  int                udrops, u0;

  tlpt_if bus ();
  tlpt_usr tlpt_usr_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .usr_valid_i(usr_valid), .usr_ready_o(usr_ready), .usr_word_i(wd),
    .usr_hold_internal_i(hold), .usr_free_bufs_o(free), .usr_drop_o(udrop),
    .usr_int_req_o(ireq));
  tlpt_dev tlpt_dev_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .int_pkt_pending_i(pend), .int_pkt_data_i(idata),
    .int_pkt_taken_o(taken), .link_ready_i(lrdy),
    .link_valid_o(lvld), .link_word_o(lword));
  tlpt_props tlpt_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .tx_data_bus(bus.tx_data_bus),
    .tx_start_of_frame(bus.tx_start_of_frame),
    .tx_end_of_frame(bus.tx_end_of_frame),
    .tx_source_valid(bus.tx_source_valid),
    .tx_sink_ready(bus.tx_sink_ready),
    .tx_source_abort(bus.tx_source_abort),
    .tx_cut_through_flag(bus.tx_cut_through_flag),
    .free_tx_buffer_count(bus.free_tx_buffer_count),
    .tx_drop_flag(bus.tx_drop_flag),
    .internal_packet_request(bus.internal_packet_request),
    .internal_packet_grant(bus.internal_packet_grant));

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc++;
    if (lvld && lrdy) got.push_back(lword);
    if (bus.tx_drop_flag) drops++;
    if (udrop) udrops++;
    if (bus.tx_source_valid && bus.tx_sink_ready && bus.tx_end_of_frame)
      eofs++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  // --------
  // shared tasks
  // --------
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic tlpt_word_s mk(input logic s, e, input logic [1:0] r,
                                    input logic [DATA_W-1:0] d);
    return '{1'b0, 1'b0, 1'b0, 1'b0, s, e, r, d};
  endfunction

  // refusal is reported through ok after a bounded wait
  task automatic send(input tlpt_word_s w, output bit ok);
    int k;
    @(negedge clk_i);
    usr_valid = 1'b1;
    wd = w;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!usr_ready && k < 20);
    ok = usr_ready;
  endtask

  task automatic idle();
    @(negedge clk_i);
    usr_valid = 1'b0;
  endtask

  task automatic pkt(input logic [1:0] r, input logic [9:0] len,
                     input logic st, gp, ab, input int dx);
    tlpt_word_s w0;
    tlpt_word_s w1;
    tlpt_word_s lw;
    int d0;
    d0 = drops;
    u0 = udrops;
    got.delete();
    w0 = mk(1'b1, 1'b0, 2'h0, {2'b01, 20'h0, len, 96'h5a});
    w0.stream = st;
    w1 = mk(1'b0, 1'b1, r, {64'h0, 64'(len)});
    w1.abort = ab;
    send(w0, ok);
    if (gp) idle();
    send(w1, ok);
    idle();
    repeat (20) @(posedge clk_i);
    chk(drops - d0, dx);
    chk(udrops - u0, dx);
    lw = got.size() ? got[$] : '0;
    chk(lw.abort, ab || dx != 0);
    if (!ab && dx == 0) begin
      chk(got.size(), 2);
      chk(lw.data, w1.data);
      chk(lw.rem, r);
    end
    $display("test packet rem %0d len %0d done", r, len);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    usr_valid = 1'b0;
    wd = '0;
    hold = 1'b1;
    pend = 1'b0;
    idata = 128'hc0de;
    lrdy = 1'b1;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk(free, 6'h20);
    chk(bus.tx_sink_ready, 1'b1);
    $display("test reset done");

    got.delete();
    wd = mk(1'b1, 1'b1, REM_ALL, {32'h4000_0001, 96'h0a0b0c});
    wd.digest = 1'b1;
    wd.poison = 1'b1;
    send(wd, ok);
    idle();
    repeat (20) @(posedge clk_i);
    chk(got.size(), 1);
    chk(got[0], wd);
    chk(drops, 0);
    $display("test digest and poison done");

    for (int r = 0; r < 4; r++) pkt(r[1:0], 10'(2 + r), 0, 0, 0, 0);
    pkt(2'h3, 10'd6, 1'b0, 1'b0, 1'b0, 1);
    pkt(2'h3, 10'd5, 1'b0, 1'b0, 1'b1, 0);
    pkt(2'h3, 10'd5, 1'b1, 1'b0, 1'b0, 0);
    pkt(2'h3, 10'd5, 1'b1, 1'b1, 1'b0, 1);

    got.delete();
    @(negedge clk_i);
    pend = 1'b1;
    repeat (10) @(posedge clk_i);
    chk(ireq, 1'b1);
    chk(got.size(), 0);
    @(negedge clk_i);
    hold = 1'b0;
    n = 0;
    // pending must fall while taken stands, or a second request rises
    do begin
      @(negedge clk_i);
      n++;
    end while (!taken && n < 20);
    chk(taken, 1'b1);
    pend = 1'b0;
    repeat (20) @(posedge clk_i);
    chk(got.size(), 1);
    chk(got[0].data, idata);
    $display("test internal packet done");

    // stall the link so the word buffer fills until it refuses
    got.delete();
    @(negedge clk_i);
    lrdy = 1'b0;
    e0 = eofs;
    i = 0;
    do begin
      send(mk(1'b1, 1'b1, REM_ALL, {32'h4000_0001, 96'(i)}), ok);
      i++;
    end while (ok && i < 40);
    @(negedge clk_i);
    usr_valid = 1'b0;
    chk(bus.tx_sink_ready, 1'b0);
    chk(free, 6'h20 - 6'(eofs - e0));
    lrdy = 1'b1;
    repeat (60) @(posedge clk_i);
    chk(got.size(), i - 1);
    for (int k = 0; k < got.size(); k++) chk(got[k].data[95:0], 96'(k));
    chk(free, 6'h20);
    $display("test buffer fill done");
    results();
  end
endmodule
